// *** core/tmrcc_pkg.sv ***
// Package with register map, field layout and encodings of the timer block.
package tmrcc_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_COUNT = 12'h004;
	localparam logic [11:0] ADDR_CCTL0 = 12'h008;
	localparam logic [11:0] ADDR_CAPTURE_COMPARE_0 = 12'h014;
	localparam logic [11:0] ADDR_VECTOR = 12'h020;
	localparam logic [11:0] ADDR_STATUS = 12'h024;
	localparam logic [11:0] ADDR_CLEAR = 12'h028;
	localparam logic [11:0] ADDR_ENABLE = 12'h02C;
	localparam logic [11:0] CH_STRIDE = 12'h004;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_CLR_POS = 2;
	localparam int CTRL_MODE_POS = 4;
	localparam int CTRL_DIV_POS = 6;
	localparam int CTRL_SRC_POS = 8;

	// Channel control fields.
	localparam int CC_OUTVAL_POS = 2;
	localparam int CC_SWIN_POS = 3;
	localparam int CC_OUTMODE_POS = 5;
	localparam int CC_CAP_POS = 8;
	localparam int CC_INSEL_POS = 12;
	localparam int CC_EDGE_POS = 14;

	// ----------------------------------------------------------------
	// Status bits and vector word values
	// ----------------------------------------------------------------
	localparam int ST_CH0 = 0;
	localparam int ST_CH1 = 1;
	localparam int ST_CH2 = 2;
	localparam int ST_OVF = 3;
	localparam logic [15:0] VEC_NONE = 16'h0000;
	localparam logic [15:0] VEC_CH1 = 16'h0002;
	localparam logic [15:0] VEC_CH2 = 16'h0004;
	localparam logic [15:0] VEC_OVF = 16'h000A;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] RST_CCTL = 16'h0000;
	localparam logic [15:0] RST_CCR = 16'h0000;

	// Clock sources and count modes.
	typedef enum logic [1:0] {
		SRC_EXT = 2'h0,
		SRC_AUX = 2'h1,
		SRC_SUB = 2'h2,
		SRC_ALT = 2'h3
	} tmrcc_src_e;

	typedef enum logic [1:0] {
		MODE_STOP = 2'h0,
		MODE_UP = 2'h1,
		MODE_CONT = 2'h2,
		MODE_UPDN = 2'h3
	} tmrcc_mode_e;

	// Per channel control.
	typedef struct packed {
		logic [1:0] edge_sel;
		logic [1:0] in_sel;
		logic [2:0] rsvd;
		logic cap;
		logic [2:0] out_mode;
		logic rsvd2;
		logic sw_in;
		logic out_val;
		logic [1:0] rsvd3;
	} tmrcc_cctl_s;

	// Timer clock inputs grouped together.
	typedef struct packed {
		logic ext_clk;
		logic aux_clk;
		logic sub_clk;
		logic alt_clk;
	} tmrcc_clks_s;

endpackage : tmrcc_pkg

// *** core/tmrcc_top.sv ***
// Sixteen-bit timer with three capture/compare channels behind an APB slave.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// R1: One 16-bit counter, three 16-bit channels.
// R2: Source 0 external pin, 3 alternate pin.
// R3: Source 1 auxiliary clock, 2 subsystem clock.
// R4: Prescaler divides by one, two, four, eight.
// R5: Counter halts, reads and writes as words.
// R6: Modes stop, continuous, up, up/down.
// R7: Each channel selects capture or compare.
// R8: Capture on rising, falling or both edges.
// R9: Software starts and stops capture anytime.
// R10: Each channel has its own event input.
// R11: Channel 2 input b is auxiliary clock.
// R12: Input select 2 or 3 is software.
// R13: Each channel drives its own output.
// R14: Output runs freely or by trigger.
// R15: Channel 0 interrupt on its own line.
// R16: Shared line with readable vector word.
// R17: Up wraps at compare 0; up/down reverses.
module tmrcc_top #(
	parameter int CHANNELS = 3,
	parameter int WIDTH = 16
) (
	// Clock, reset and freeze.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer clock inputs, sampled as levels.
	input wire tmrcc_pkg::tmrcc_clks_s clks,
	// Event inputs and output pins.
	input wire logic [CHANNELS-1:0] timer_event_in,
	output logic [CHANNELS-1:0] timer_out,
	// Interrupts.
	output logic irq_ch0,
	output logic irq_shared
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] ctrl_reg, ctrl_next;
	logic [WIDTH-1:0] count_reg, count_next;
	logic down_reg, down_next;
	logic [2:0] pre_reg, pre_next;
	logic clk_smp_reg, clk_smp_next;
	tmrcc_pkg::tmrcc_cctl_s [CHANNELS-1:0] cctl_reg, cctl_next;
	logic [CHANNELS-1:0][WIDTH-1:0] ccr_reg, ccr_next;
	logic [CHANNELS-1:0] capin_reg, capin_next;
	logic [CHANNELS-1:0] out_reg, out_next;
	logic [3:0] status_reg, status_next;
	logic [3:0] enable_reg, enable_next;
	logic [31:0] prdata_reg, prdata_next;

	// Decoded fields.
	tmrcc_pkg::tmrcc_mode_e mode;
	tmrcc_pkg::tmrcc_src_e src;
	logic [1:0] div;
	logic sel_clk, tick, wr, rd;
	logic [CHANNELS-1:0] cap_src, cap_evt, cmp_evt;
	logic [3:0] ev;
	logic [WIDTH-1:0] period;

	assign mode = tmrcc_pkg::tmrcc_mode_e'(ctrl_reg[tmrcc_pkg::CTRL_MODE_POS +: 2]);
	assign src = tmrcc_pkg::tmrcc_src_e'(ctrl_reg[tmrcc_pkg::CTRL_SRC_POS +: 2]);
	assign div = ctrl_reg[tmrcc_pkg::CTRL_DIV_POS +: 2];
	assign period = ccr_reg[0];
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// Byte address of a channel's control or compare word.
	function automatic logic [11:0] ch_addr(input logic [11:0] base, input int ch);
		ch_addr = base + 12'(ch) * tmrcc_pkg::CH_STRIDE;
	endfunction : ch_addr

	// ----------------------------------------------------------------
	// Clock selection and prescaler
	// ----------------------------------------------------------------
	// The chosen clock is sampled and a rising edge advances the prescaler, so the
	// timer clocks must run well below pclk.
	always_comb begin
		case (src)
			tmrcc_pkg::SRC_EXT: sel_clk = clks.ext_clk; // [R2]
			tmrcc_pkg::SRC_ALT: sel_clk = clks.alt_clk; // [R2]
			tmrcc_pkg::SRC_AUX: sel_clk = clks.aux_clk; // [R3]
			default: sel_clk = clks.sub_clk; // [R3]
		endcase
		clk_smp_next = sel_clk;
		pre_next = pre_reg;
		tick = 1'b0;
		if (sel_clk && !clk_smp_reg) begin
			if (pre_reg >= 3'((1 << div) - 1)) begin // [R4]
				pre_next = 3'h0;
				tick = 1'b1;
			end else begin
				pre_next = pre_reg + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Counter events and compare matches are evaluated on ticks only.
	always_comb begin
		count_next = count_reg;
		down_next = down_reg;
		ev = 4'h0;
		if (tick) begin
			case (mode)
				tmrcc_pkg::MODE_CONT: begin // [R6]
					count_next = count_reg + WIDTH'(1);
					ev[tmrcc_pkg::ST_OVF] = &count_reg;
				end
				tmrcc_pkg::MODE_UP: begin // [R6]
					if (count_reg >= period) begin // [R17]
						count_next = '0;
						ev[tmrcc_pkg::ST_OVF] = 1'b1;
					end else begin
						count_next = count_reg + WIDTH'(1);
					end
				end
				tmrcc_pkg::MODE_UPDN: begin // [R6]
					if (!down_reg && count_reg >= period) begin // [R17]
						down_next = 1'b1;
						count_next = count_reg - WIDTH'(1);
					end else if (down_reg && count_reg <= WIDTH'(1)) begin // [R17]
						down_next = 1'b0;
						count_next = '0;
						ev[tmrcc_pkg::ST_OVF] = 1'b1;
					end else begin
						count_next = down_reg ? count_reg - WIDTH'(1) : count_reg + WIDTH'(1);
					end
				end
				default: count_next = count_reg; // [R6]
			endcase
		end
		if (ctrl_reg[tmrcc_pkg::CTRL_CLR_POS]) begin
			count_next = '0;
			down_next = 1'b0;
		end
		if (wr && paddr == tmrcc_pkg::ADDR_COUNT) begin
			count_next = pwdata[WIDTH-1:0]; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	// Capture edges are detected at pclk rate on the sampled input.
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			always_comb begin
				case (cctl_reg[g].in_sel)
					2'h0: cap_src[g] = timer_event_in[g]; // [R10]
					2'h1: cap_src[g] = (g == 2) ? clks.aux_clk : timer_event_in[g]; // [R11]
					default: cap_src[g] = cctl_reg[g].sw_in; // [R12]
				endcase
				capin_next[g] = cap_src[g];
				cap_evt[g] = cctl_reg[g].cap && // [R7] [R9]
					((cctl_reg[g].edge_sel[0] && cap_src[g] && !capin_reg[g]) || // [R8]
					(cctl_reg[g].edge_sel[1] && !cap_src[g] && capin_reg[g])); // [R8]
				cmp_evt[g] = !cctl_reg[g].cap && tick && count_next == ccr_reg[g];
				cctl_next[g] = cctl_reg[g];
				ccr_next[g] = ccr_reg[g];
				if (wr && paddr == ch_addr(tmrcc_pkg::ADDR_CCTL0, g)) begin
					cctl_next[g] = pwdata[15:0]; // [R9]
				end
				if (wr && paddr == ch_addr(tmrcc_pkg::ADDR_CAPTURE_COMPARE_0, g)) begin
					ccr_next[g] = pwdata[WIDTH-1:0];
				end
				if (cap_evt[g]) begin
					ccr_next[g] = count_reg; // [R8]
				end
				// Output module: mode 0 follows the software value; 1, 2, 3, 5 and 7 fire on
				// a compare match, 3 and 7 also switching at the period end; 4 and 6 hold.
				out_next[g] = out_reg[g];
				case (cctl_reg[g].out_mode)
					3'h0: out_next[g] = cctl_reg[g].out_val; // [R14]
					3'h1: if (cmp_evt[g]) out_next[g] = 1'b1; // [R14]
					3'h2: if (cmp_evt[g]) out_next[g] = !out_reg[g]; // [R14]
					3'h3: if (cmp_evt[g]) out_next[g] = 1'b1;
						else if (ev[tmrcc_pkg::ST_OVF]) out_next[g] = 1'b0;
					3'h5: if (cmp_evt[g]) out_next[g] = 1'b0;
					3'h7: if (cmp_evt[g]) out_next[g] = 1'b0;
						else if (ev[tmrcc_pkg::ST_OVF]) out_next[g] = 1'b1;
					default: out_next[g] = out_reg[g];
				endcase
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Interrupt status and vector
	// ----------------------------------------------------------------
	// A new event in the clearing cycle wins, so no event is lost.
	logic [3:0] evt_all;
	logic [3:0] pend;
	logic [15:0] vector;
	assign evt_all = {ev[tmrcc_pkg::ST_OVF], cap_evt | cmp_evt};
	assign pend = status_reg & enable_reg;
	always_comb begin
		status_next = status_reg;
		enable_next = enable_reg;
		if (wr && paddr == tmrcc_pkg::ADDR_CLEAR) begin
			status_next = status_reg & ~pwdata[3:0];
		end
		if (wr && paddr == tmrcc_pkg::ADDR_ENABLE) begin
			enable_next = pwdata[3:0];
		end
		status_next = status_next | evt_all;
		// Highest priority pending source of the shared line.
		if (pend[tmrcc_pkg::ST_CH1]) begin
			vector = tmrcc_pkg::VEC_CH1; // [R16]
		end else if (pend[tmrcc_pkg::ST_CH2]) begin
			vector = tmrcc_pkg::VEC_CH2; // [R16]
		end else if (pend[tmrcc_pkg::ST_OVF]) begin
			vector = tmrcc_pkg::VEC_OVF; // [R16]
		end else begin
			vector = tmrcc_pkg::VEC_NONE;
		end
	end
	assign irq_ch0 = pend[tmrcc_pkg::ST_CH0]; // [R15]
	assign irq_shared = |pend[3:1]; // [R16]

	// ----------------------------------------------------------------
	// Control register and read data
	// ----------------------------------------------------------------
	// Read data is prepared in setup so the access phase ends at once.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr && paddr == tmrcc_pkg::ADDR_CTRL) begin
			ctrl_next = pwdata[15:0];
		end else begin
			ctrl_next[tmrcc_pkg::CTRL_CLR_POS] = 1'b0;
		end
		prdata_next = prdata_reg;
		if (rd) begin
			prdata_next = 32'h0000_0000;
			if (paddr == tmrcc_pkg::ADDR_CTRL) begin
				prdata_next[15:0] = ctrl_reg;
			end else if (paddr == tmrcc_pkg::ADDR_COUNT) begin
				prdata_next[WIDTH-1:0] = count_reg; // [R5]
			end else if (paddr == tmrcc_pkg::ADDR_VECTOR) begin
				prdata_next[15:0] = vector; // [R16]
			end else if (paddr == tmrcc_pkg::ADDR_STATUS) begin
				prdata_next[3:0] = status_reg;
			end else if (paddr == tmrcc_pkg::ADDR_ENABLE) begin
				prdata_next[3:0] = enable_reg;
			end else begin
				for (int i = 0; i < CHANNELS; i++) begin
					if (paddr == ch_addr(tmrcc_pkg::ADDR_CCTL0, i)) begin
						prdata_next[15:0] = cctl_reg[i];
					end else if (paddr == ch_addr(tmrcc_pkg::ADDR_CAPTURE_COMPARE_0, i)) begin
						prdata_next[WIDTH-1:0] = ccr_reg[i]; // [R1]
					end
				end
			end
		end
	end
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_reg;
	assign timer_out = out_reg; // [R13]

	// Register all state; clk_en low freezes everything.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= tmrcc_pkg::RST_CTRL;
			count_reg <= '0;
			down_reg <= 1'b0;
			pre_reg <= 3'h0;
			clk_smp_reg <= 1'b0;
			cctl_reg <= '0;
			ccr_reg <= '0;
			capin_reg <= '0;
			out_reg <= '0;
			status_reg <= 4'h0;
			enable_reg <= 4'h0;
			prdata_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			count_reg <= count_next;
			down_reg <= down_next;
			pre_reg <= pre_next;
			clk_smp_reg <= clk_smp_next;
			cctl_reg <= cctl_next;
			ccr_reg <= ccr_next;
			capin_reg <= capin_next;
			out_reg <= out_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			prdata_reg <= prdata_next;
		end
	end

endmodule : tmrcc_top

// *** tb/tmrcc_far_model.sv ***
// Pin-side model: timer clock sources and capture event inputs.
`timescale 1ns/10ps
module tmrcc_far_model (
	// Clock and commands from the bench.
	input wire logic pclk,
	input wire logic [3:0] run,
	input wire logic [2:0] ev,
	// Pins into the timer.
	output tmrcc_pkg::tmrcc_clks_s clks,
	output logic [2:0] timer_event_in
);
	logic ph = 1'b0;

	// A running source toggles every second cycle; a stopped one parks low,
	// so halting a source never leaves a stray rising edge.
	always @(posedge pclk) begin
		ph <= ~ph;
		clks <= run & (clks ^ {4{ph}});
		timer_event_in <= ev;
	end
endmodule : tmrcc_far_model

// *** tb/tmrcc_top_assertions.sv ***
// Concurrent checks on the ports of the timer block.
`timescale 1ns/10ps
module tmrcc_top_assertions (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupts.
	input wire logic irq_ch0,
	input wire logic irq_shared
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Read data is loaded at the setup edge only, so it must hold otherwise.
	sequence rd_setup;
		psel && !penable && !pwrite;
	endsequence
	sequence enable_off;
		psel && penable && pwrite && paddr == 12'h02C && pwdata[3:0] == 4'h0;
	endsequence

	a_ready_access: assert property (psel && penable |-> pready && !pslverr)
		else $error("access phase not answered cleanly");
	a_read_upper: assert property (rd_setup ##1 penable |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_read_unmapped: assert property (psel && !penable && !pwrite && paddr >= 12'h030 |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside a read");
	a_vector_code: assert property (psel && !penable && !pwrite && paddr == 12'h020
		|=> prdata inside {32'h0, 32'h2, 32'h4, 32'hA})
		else $error("vector word not a legal offset");
	a_vector_pending: assert property (psel && !penable && !pwrite && paddr == 12'h020 && irq_shared
		|=> prdata[15:0] != 16'h0000)
		else $error("shared line high with empty vector");
	a_enable_quiet: assert property (enable_off |=> !irq_ch0 && !irq_shared)
		else $error("interrupt stays high after disable");
	a_reset_quiet: assert property ($rose(presetn) |-> !irq_ch0 && !irq_shared)
		else $error("interrupt high after reset");
endmodule : tmrcc_top_assertions

bind tmrcc_top tmrcc_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_ch0(irq_ch0), .irq_shared(irq_shared));

// *** tb/tb_top.sv ***
// Self-checking bench for the timer block.
`timescale 1ns/10ps
module tb_top;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq_ch0, irq_shared;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] run;
	logic [2:0] ev, timer_event_in, timer_out;
	tmrcc_pkg::tmrcc_clks_s clks;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;

	// Design with its pins wired to the model; one scenario drops the freeze input.
	tmrcc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clks(clks), .timer_event_in(timer_event_in),
		.timer_out(timer_out), .irq_ch0(irq_ch0), .irq_shared(irq_shared));
	tmrcc_far_model far (.pclk(pclk), .run(run), .ev(ev), .clks(clks),
		.timer_event_in(timer_event_in));

	// Bus clock of 8 ns.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// A hang ends the run far beyond the several hundred cycles expected.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// The request holds until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		logic [31:0] q;
		apb(1'b0, a, 16'h0000, q);
		chk($sformatf("reg %h", a), {16'h0000, e}, q);
	endtask : rdc

	// Runs one source for n rising edges, then lets the sampler settle.
	task automatic pulse(input int s, input int n);
		run <= 4'(8 >> s);
		repeat (4 * n) @(posedge pclk);
		run <= 4'h0;
		repeat (4) @(posedge pclk);
	endtask : pulse

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_sources;
		for (int s = 0; s < 4; s++) begin
			wr(12'h000, 16'(s * 256) | 16'h0024);
			pulse(s, 3 + s);
			rdc(12'h004, 16'(3 + s));
		end
	endtask : sc_sources

	task automatic sc_divider;
		for (int d = 1; d < 4; d++) begin
			wr(12'h000, 16'(d * 64) | 16'h0024);
			pulse(0, 16);
			rdc(12'h004, 16'(16 >> d));
		end
	endtask : sc_divider

	task automatic sc_halt;
		wr(12'h000, 16'h0000);
		wr(12'h004, 16'h1234);
		pulse(0, 4);
		rdc(12'h004, 16'h1234);
		rdc(12'h030, 16'h0000);
	endtask : sc_halt

	// Other channels compare far away so only wrap and channel 0 fire.
	task automatic sc_modes;
		wr(12'h018, 16'h0100);
		wr(12'h01C, 16'h0100);
		wr(12'h014, 16'h0003);
		wr(12'h028, 16'h000F);
		wr(12'h02C, 16'h000F);
		wr(12'h008, 16'h0020);
		wr(12'h000, 16'h0014);
		pulse(0, 4);
		rdc(12'h004, 16'h0000);
		chk("irq_ch0", 1, irq_ch0);
		chk("irq_shared", 1, irq_shared);
		chk("timer_out0", 1, timer_out[0]);
		rdc(12'h020, tmrcc_pkg::VEC_OVF);
		wr(12'h028, 16'h000F);
		chk("irq pair", 0, {irq_ch0, irq_shared});
		wr(12'h000, 16'h0034);
		pulse(0, 4);
		rdc(12'h004, 16'h0002);
	endtask : sc_modes

	task automatic sc_capture;
		wr(12'h000, 16'h0000);
		wr(12'h028, 16'h000F);
		wr(12'h004, 16'h0055);
		wr(12'h00C, 16'h8104);
		ev <= 3'b010;
		repeat (4) @(posedge pclk);
		rdc(12'h018, 16'h0100);
		chk("timer_out1", 1, timer_out[1]);
		ev <= 3'b000;
		repeat (4) @(posedge pclk);
		rdc(12'h018, 16'h0055);
		rdc(12'h020, tmrcc_pkg::VEC_CH1);
		wr(12'h004, 16'h0066);
		wr(12'h010, 16'h5100);
		pulse(1, 1);
		rdc(12'h01C, 16'h0066);
		wr(12'h028, 16'h0002);
		rdc(12'h020, tmrcc_pkg::VEC_CH2);
		wr(12'h004, 16'h0077);
		wr(12'h008, 16'hE100);
		wr(12'h008, 16'hE108);
		repeat (2) @(posedge pclk);
		rdc(12'h014, 16'h0077);
		wr(12'h008, 16'hF108);
		wr(12'h004, 16'h0088);
		wr(12'h008, 16'hF100);
		repeat (2) @(posedge pclk);
		rdc(12'h014, 16'h0088);
		wr(12'h004, 16'h0099);
		wr(12'h008, 16'hF008);
		repeat (2) @(posedge pclk);
		rdc(12'h014, 16'h0088);
		rdc(12'h024, 16'h0005);
		rdc(12'h02C, 16'h000F);
		chk("irq pair", 3, {irq_ch0, irq_shared});
		wr(12'h02C, 16'h0000);
		chk("irq pair", 0, {irq_ch0, irq_shared});
		rdc(12'h020, tmrcc_pkg::VEC_NONE);
	endtask : sc_capture

	// Toggle, set/reset and reset/set at wrap, then plain reset, in up mode.
	task automatic sc_outputs;
		wr(12'h014, 16'h0003);
		wr(12'h018, 16'h0001);
		wr(12'h01C, 16'h0002);
		wr(12'h008, 16'h0040);
		wr(12'h00C, 16'h0060);
		wr(12'h010, 16'h00E0);
		wr(12'h000, 16'h0014);
		rdc(12'h000, 16'h0010);
		rdc(12'h00C, 16'h0060);
		pulse(0, 3);
		chk("timer_out", 3'b011, timer_out);
		pulse(0, 1);
		chk("timer_out", 3'b101, timer_out);
		wr(12'h010, 16'h00A0);
		pulse(0, 2);
		chk("timer_out", 3'b011, timer_out);
	endtask : sc_outputs

	// Ticks that arrive while the freeze input is low must be lost.
	task automatic sc_freeze;
		wr(12'h000, 16'h0024);
		clk_en <= 1'b0;
		pulse(0, 3);
		clk_en <= 1'b1;
		@(posedge pclk);
		rdc(12'h004, 16'h0000);
		pulse(0, 2);
		rdc(12'h004, 16'h0002);
	endtask : sc_freeze

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// Reset for two cycles, then the scenarios in turn.
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		run = 4'h0;
		ev = 3'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		sc_sources();
		sc_divider();
		sc_halt();
		sc_modes();
		sc_capture();
		sc_outputs();
		sc_freeze();
		tally_and_finish();
	end
endmodule : tb_top
